// file: src/timer_unit_consts.vh
// Register addresses, field positions and mode codes of the triple timer/counter unit.
`ifndef TIMER_UNIT_CONSTS_VH
`define TIMER_UNIT_CONSTS_VH

// Byte addresses of the timer registers on the core register port.
`define ADDR_CTL01      8'h88
`define ADDR_MODE01     8'h89
`define ADDR_LOW0       8'h8A
`define ADDR_LOW1       8'h8B
`define ADDR_HIGH0      8'h8C
`define ADDR_HIGH1      8'h8D
`define ADDR_CTL2       8'hC8
`define ADDR_RELOAD_LO  8'hCA
`define ADDR_RELOAD_HI  8'hCB
`define ADDR_LOW2       8'hCC
`define ADDR_HIGH2      8'hCD

// Upper five bits of a bit address that select a bit-addressable register.
`define BITBASE_CTL01   5'h11
`define BITBASE_CTL2    5'h19

// Bit positions in the timer 0/1 control register.
`define CTL_FLAG1       7
`define CTL_RUN1        6
`define CTL_FLAG0       5
`define CTL_RUN0        4

// Bit positions in the timer 0/1 mode register.
`define MOD_TIMER_ONE_PIN_GATING       7
`define MOD_SRC1        6
`define MOD_MODE1_HI    5
`define MOD_MODE1_LO    4
`define MOD_GATE0       3
`define MOD_SRC0        2
`define MOD_MODE0_HI    1
`define MOD_MODE0_LO    0

// Bit positions in the timer 2 control register.
`define CTL2_FLAG       7
`define CTL2_RUN        2
`define CTL2_SRC        1

// Operating modes of timers 0 and 1.
`define MODE_PRESCALE   2'h0
`define MODE_CASCADE    2'h1
`define MODE_RELOAD     2'h2
`define MODE_SPLIT      2'h3

// Counter limits and reset values.
`define BYTE_MAX        8'hFF
`define WORD_MAX        16'hFFFF
`define PRESC_MAX       5'h1F
`define PRESC_MSB       4
`define BYTE_RESET      8'h00

// Index of each sampled pin in the sampler bank.
`define PIN_COUNT       5
`define PIN_CNT0        0
`define PIN_CNT1        1
`define PIN_CNT2        2
`define PIN_EXT0        3
`define PIN_EXT1        4

`endif

// file: src/pin_fall_sampler.v
// Two-flop pin synchroniser with a falling-edge detector behind it.
`timescale 1ns/100ps
`default_nettype none
module pin_fall_sampler (
  input  wire clk_i,      // Core clock.
  input  wire sys_rst_i,  // Synchronous reset, active high.
  input  wire pin_i,      // Asynchronous pin level.
  output wire level_o,    // Synchronised level.
  output wire fall_o      // One-cycle pulse on a sampled 1-to-0 change.
);
  reg meta_reg;  // First stage, read only by the second stage.
  reg sync_reg;  // Second stage, safe to use.
  reg prev_reg;  // Previous cycle's safe sample.

  // A fall is seen when one sample is high and the next is low, so two cycles per event.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_o = sync_reg;
  assign fall_o  = prev_reg & ~sync_reg;
endmodule // pin_fall_sampler
`default_nettype wire

// file: src/mode_byte_counter.v
// One timer built from a low and a high byte, counting in one of four modes.
`timescale 1ns/100ps
`default_nettype none
`include "timer_unit_consts.vh"
module mode_byte_counter (
  input  wire       clk_i,       // Core clock.
  input  wire       sys_rst_i,   // Synchronous reset, active high.
  input  wire [1:0] mode_i,      // Operating mode.
  input  wire       low_tick_i,  // Count request for the low byte path.
  input  wire       high_tick_i, // Count request for the high byte in split mode.
  input  wire       wr_low_i,    // Core writes the low byte.
  input  wire       wr_high_i,   // Core writes the high byte.
  input  wire [7:0] wdata_i,     // Core write data.
  output wire [7:0] low_o,       // Low byte value.
  output wire [7:0] high_o,      // High byte value.
  output reg        ovf_o,       // Pulse: counter of the main path wrapped.
  output reg        high_ovf_o   // Pulse: split-mode high byte wrapped.
);
  reg [7:0]  counter_low_byte_reg;   // Low byte.
  reg [7:0]  counter_high_byte_reg;  // High byte.
  reg [7:0]  low_next;               // Next low byte.
  reg [7:0]  high_next;              // Next high byte.
  reg [15:0] word_sum;               // Cascaded sum for 16-bit mode.

  // Next-state logic; a core write wins over a count in the same cycle.
  always @* begin
    low_next   = counter_low_byte_reg;
    high_next  = counter_high_byte_reg;
    ovf_o      = 1'b0;
    high_ovf_o = 1'b0;
    word_sum   = {counter_high_byte_reg, counter_low_byte_reg} + 16'h0001;
    if (low_tick_i) begin
      case (mode_i)
        `MODE_PRESCALE: begin
          // Only the five prescaler bits move; the upper three hold.
          low_next[`PRESC_MSB:0] = counter_low_byte_reg[`PRESC_MSB:0] + 5'h01;
          if (counter_low_byte_reg[`PRESC_MSB:0] == `PRESC_MAX) begin
            high_next = counter_high_byte_reg + 8'h01;
            ovf_o     = (counter_high_byte_reg == `BYTE_MAX);
          end
        end
        `MODE_CASCADE: begin
          // Both bytes form one 16-bit counter.
          {high_next, low_next} = word_sum;
          ovf_o = ({counter_high_byte_reg, counter_low_byte_reg} == `WORD_MAX);
        end
        `MODE_RELOAD: begin
          // The high byte is the reload value for the low byte.
          if (counter_low_byte_reg == `BYTE_MAX) begin
            low_next = counter_high_byte_reg;
            ovf_o    = 1'b1;
          end else begin
            low_next = counter_low_byte_reg + 8'h01;
          end
        end
        `MODE_SPLIT: begin
          // The low byte alone is an 8-bit counter.
          low_next = counter_low_byte_reg + 8'h01;
          ovf_o    = (counter_low_byte_reg == `BYTE_MAX);
        end
        default: begin
          low_next = counter_low_byte_reg;
        end
      endcase
    end
    // In split mode the high byte is a separate timer with its own enable.
    if (high_tick_i && (mode_i == `MODE_SPLIT)) begin
      high_next  = counter_high_byte_reg + 8'h01;
      high_ovf_o = (counter_high_byte_reg == `BYTE_MAX);
    end
    if (wr_low_i) begin
      low_next = wdata_i;
    end
    if (wr_high_i) begin
      high_next = wdata_i;
    end
  end

  // Byte storage.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      counter_low_byte_reg  <= `BYTE_RESET;
      counter_high_byte_reg <= `BYTE_RESET;
    end else begin
      counter_low_byte_reg  <= low_next;
      counter_high_byte_reg <= high_next;
    end
  end

  assign low_o  = counter_low_byte_reg;
  assign high_o = counter_high_byte_reg;
endmodule // mode_byte_counter
`default_nettype wire

// file: src/triple_timer_counter_unit.v
// Three 16-bit timer/counters reached through the core's special function registers.
//
// Overview of operation
// - Three 16-bit timers, each two bytes, timer/counter.
// - Timer mode: low byte counts every clock.
// - Counter mode: count sampled high-then-low pin transitions.
// - Edge detection needs two cycles, half rate.
// - Timer 1 gate: run needs interrupt pin high.
// - Timer 1 source bit picks pin or clock.
// - Mode 00: high byte fed by 5-bit prescaler.
// - Two control registers are bit-addressable, others byte.
// - Timer 2 reload pair at 0xCA/0xCB, read-write.
// - Modes 01 cascade, 10 autoreload, 11 stops timer 1.
// - Timer 0 mode 11 splits bytes; high uses timer 1 run.
// - Overflow sets flag; vectoring clears timer 0/1 flags, timer 2 flag only by software.
`timescale 1ns/100ps
`default_nettype none
`include "timer_unit_consts.vh"
module triple_timer_counter_unit (
  input  wire       clk_i,                         // Core clock, 100 MHz.
  input  wire       sys_rst_i,                     // Synchronous reset, active high.
  input  wire [7:0] sfr_addr_i,                    // Byte register address.
  input  wire       sfr_wr_i,                      // Byte write strobe.
  input  wire       sfr_rd_i,                      // Byte read strobe.
  input  wire [7:0] sfr_wdata_i,                   // Byte write data.
  output wire [7:0] sfr_rdata_o,                   // Read data, valid the cycle after a read.
  input  wire [7:0] bit_addr_i,                    // Bit address for single-bit writes.
  input  wire       bit_wr_i,                      // Single-bit write strobe.
  input  wire       bit_wdata_i,                   // Single-bit write value.
  input  wire       count_input_pin_zero_i,        // Timer 0 external count pin.
  input  wire       count_input_pin_one_i,         // Timer 1 external count pin.
  input  wire       count_input_pin_two_i,         // Timer 2 external count pin.
  input  wire       external_interrupt_pin_zero_i, // Timer 0 gating pin.
  input  wire       external_interrupt_pin_one_i,  // Timer 1 gating pin.
  input  wire       vector_timer_zero_i,           // Pulse: core vectors to timer 0 routine.
  input  wire       vector_timer_one_i,            // Pulse: core vectors to timer 1 routine.
  output wire       timer_zero_overflow_flag_o,    // Timer 0 overflow flag.
  output wire       timer_one_overflow_flag_o,     // Timer 1 overflow flag.
  output wire       timer_two_overflow_flag_o      // Timer 2 overflow flag.
);
  // Sampled pins: synchronised levels and falling-edge pulses.
  wire [`PIN_COUNT-1:0] pin_raw;    // Raw pin bank.
  wire [`PIN_COUNT-1:0] pin_level;  // Synchronised levels.
  wire [`PIN_COUNT-1:0] pin_fall;   // Falling-edge pulses.

  // Core-visible registers.
  reg  [7:0]  timer01_control_reg;       // Run bits, flags and spare bits.
  reg  [7:0]  timer01_control_next;      // Next control value.
  reg  [7:0]  timer01_mode_reg;          // Gating, source and mode fields.
  reg  [7:0]  timer_two_control_reg;     // Timer 2 run, source and flag.
  reg  [7:0]  timer_two_control_next;    // Next timer 2 control value.
  reg  [7:0]  timer_two_reload_low_reg;  // Timer 2 reload low byte.
  reg  [7:0]  timer_two_reload_high_reg; // Timer 2 reload high byte.
  reg  [15:0] timer_two_count_reg;       // Timer 2 high and low bytes.
  reg  [15:0] timer_two_count_next;      // Next timer 2 count.
  reg         timer_two_ovf;             // Pulse: timer 2 wrapped.
  reg  [7:0]  rdata_reg;                 // Registered read data.
  reg  [7:0]  rdata_next;                // Read multiplexer output.

  // Decoded strobes.
  wire        wr_ctl01;       // Byte write to the timer 0/1 control register.
  wire        wr_mode01;      // Byte write to the mode register.
  wire        wr_ctl2;        // Byte write to the timer 2 control register.
  wire        bit_hit_ctl01;  // Bit write lands in the timer 0/1 control register.
  wire        bit_hit_ctl2;   // Bit write lands in the timer 2 control register.

  // Field views of the control and mode registers.
  wire        timer_zero_run;              // Timer 0 run bit.
  wire        timer_one_run;               // Timer 1 run bit.
  wire        timer_one_pin_gating;        // Timer 1 gated by its interrupt pin.
  wire        timer_one_source_select;     // Timer 1 counts its pin when set.
  wire        timer_zero_pin_gating;       // Timer 0 gated by its interrupt pin.
  wire        timer_zero_source_select;    // Timer 0 counts its pin when set.
  wire [1:0]  timer_zero_mode;             // Timer 0 mode field.
  wire [1:0]  timer_one_mode;              // Timer 1 mode field.
  wire        timer_two_run;               // Timer 2 run bit.
  wire        timer_two_source_select;     // Timer 2 counts its pin when set.

  // Count requests and overflow pulses.
  wire        timer_zero_enable;   // Timer 0 running after gating.
  wire        timer_one_enable;    // Timer 1 running after gating and mode stop.
  wire        timer_zero_tick;     // Timer 0 low path count request.
  wire        timer_zero_split_tick; // Split-mode high byte count request.
  wire        timer_one_tick;      // Timer 1 count request.
  wire        timer_two_tick;      // Timer 2 count request.
  wire        timer_zero_ovf;      // Timer 0 main overflow.
  wire        timer_zero_high_ovf; // Timer 0 split high byte overflow.
  wire        timer_one_ovf;       // Timer 1 overflow.
  wire        flag_one_set;        // Hardware set of the timer 1 flag.
  wire [7:0]  timer_zero_low_byte;  // Timer 0 low byte.
  wire [7:0]  timer_zero_high_byte; // Timer 0 high byte.
  wire [7:0]  timer_one_low_byte;   // Timer 1 low byte.
  wire [7:0]  timer_one_high_byte;  // Timer 1 high byte.

  assign pin_raw[`PIN_CNT0] = count_input_pin_zero_i;
  assign pin_raw[`PIN_CNT1] = count_input_pin_one_i;
  assign pin_raw[`PIN_CNT2] = count_input_pin_two_i;
  assign pin_raw[`PIN_EXT0] = external_interrupt_pin_zero_i;
  assign pin_raw[`PIN_EXT1] = external_interrupt_pin_one_i;

  // Every pin is synchronised before use; the edge detector needs two samples per event.
  // The external source must hold each level one full cycle or a pulse may be missed.
  genvar pin_idx;
  generate
    for (pin_idx = 0; pin_idx < `PIN_COUNT; pin_idx = pin_idx + 1) begin : g_pin
      pin_fall_sampler u_sampler (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (pin_raw[pin_idx]),
        .level_o   (pin_level[pin_idx]),
        .fall_o    (pin_fall[pin_idx])
      );
    end
  endgenerate

  // Address decode; only the two control registers take bit writes.
  assign wr_ctl01      = sfr_wr_i & (sfr_addr_i == `ADDR_CTL01);
  assign wr_mode01     = sfr_wr_i & (sfr_addr_i == `ADDR_MODE01);
  assign wr_ctl2       = sfr_wr_i & (sfr_addr_i == `ADDR_CTL2);
  assign bit_hit_ctl01 = bit_wr_i & (bit_addr_i[7:3] == `BITBASE_CTL01);
  assign bit_hit_ctl2  = bit_wr_i & (bit_addr_i[7:3] == `BITBASE_CTL2);

  assign timer_zero_run           = timer01_control_reg[`CTL_RUN0];
  assign timer_one_run            = timer01_control_reg[`CTL_RUN1];
  assign timer_one_pin_gating     = timer01_mode_reg[`MOD_TIMER_ONE_PIN_GATING];
  assign timer_one_source_select  = timer01_mode_reg[`MOD_SRC1];
  assign timer_zero_pin_gating    = timer01_mode_reg[`MOD_GATE0];
  assign timer_zero_source_select = timer01_mode_reg[`MOD_SRC0];
  assign timer_zero_mode = {timer01_mode_reg[`MOD_MODE0_HI], timer01_mode_reg[`MOD_MODE0_LO]};
  assign timer_one_mode  = {timer01_mode_reg[`MOD_MODE1_HI], timer01_mode_reg[`MOD_MODE1_LO]};
  assign timer_two_run            = timer_two_control_reg[`CTL2_RUN];
  assign timer_two_source_select  = timer_two_control_reg[`CTL2_SRC];

  // Run control: the run bit alone, or the run bit and a high pin when gated; mode 11 also stops timer 1.
  assign timer_zero_enable = timer_zero_run & (~timer_zero_pin_gating | pin_level[`PIN_EXT0]);
  assign timer_one_enable  = timer_one_run & (~timer_one_pin_gating | pin_level[`PIN_EXT1]) &
                             (timer_one_mode != `MODE_SPLIT);

  // Source choice: every clock as a timer, or each sampled falling edge as a counter.
  assign timer_zero_tick = timer_zero_enable &
                           (~timer_zero_source_select | pin_fall[`PIN_CNT0]);
  assign timer_one_tick  = timer_one_enable &
                           (~timer_one_source_select | pin_fall[`PIN_CNT1]);
  assign timer_two_tick  = timer_two_run &
                           (~timer_two_source_select | pin_fall[`PIN_CNT2]);

  // The split high byte always counts clocks and borrows timer 1's run bit.
  assign timer_zero_split_tick = timer_one_run;

  // Timer 0 counter.
  mode_byte_counter u_timer_zero (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .mode_i      (timer_zero_mode),
    .low_tick_i  (timer_zero_tick),
    .high_tick_i (timer_zero_split_tick),
    .wr_low_i    (sfr_wr_i & (sfr_addr_i == `ADDR_LOW0)),
    .wr_high_i   (sfr_wr_i & (sfr_addr_i == `ADDR_HIGH0)),
    .wdata_i     (sfr_wdata_i),
    .low_o       (timer_zero_low_byte),
    .high_o      (timer_zero_high_byte),
    .ovf_o       (timer_zero_ovf),
    .high_ovf_o  (timer_zero_high_ovf)
  );

  // Timer 1 counter; its split mode is never used because mode 11 stops it.
  mode_byte_counter u_timer_one (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .mode_i      (timer_one_mode),
    .low_tick_i  (timer_one_tick),
    .high_tick_i (1'b0),
    .wr_low_i    (sfr_wr_i & (sfr_addr_i == `ADDR_LOW1)),
    .wr_high_i   (sfr_wr_i & (sfr_addr_i == `ADDR_HIGH1)),
    .wdata_i     (sfr_wdata_i),
    .low_o       (timer_one_low_byte),
    .high_o      (timer_one_high_byte),
    .ovf_o       (timer_one_ovf),
    .high_ovf_o  ()
  );

  // Timer 1 keeps its count in that mode, but it no longer owns a flag of its own.
  // In timer 0 split mode the timer 1 flag belongs to timer 0's high byte.
  assign flag_one_set = (timer_zero_mode == `MODE_SPLIT) ? timer_zero_high_ovf : timer_one_ovf;

  // Control register update: software write, then vector clear, then hardware set.
  // Set is applied last so an overflow in the clearing cycle is not lost.
  always @* begin
    timer01_control_next = timer01_control_reg;
    if (wr_ctl01) begin
      timer01_control_next = sfr_wdata_i;
    end
    if (bit_hit_ctl01) begin
      timer01_control_next[bit_addr_i[2:0]] = bit_wdata_i;
    end
    if (vector_timer_zero_i) begin
      timer01_control_next[`CTL_FLAG0] = 1'b0;
    end
    if (vector_timer_one_i) begin
      timer01_control_next[`CTL_FLAG1] = 1'b0;
    end
    if (timer_zero_ovf) begin
      timer01_control_next[`CTL_FLAG0] = 1'b1;
    end
    if (flag_one_set) begin
      timer01_control_next[`CTL_FLAG1] = 1'b1;
    end
  end

  // A core write to a count byte wins over a count in the same cycle, so that count is lost.
  // Timer 2: a 16-bit counter that reloads from the reload pair on overflow.
  always @* begin
    timer_two_count_next = timer_two_count_reg;
    timer_two_ovf        = 1'b0;
    if (timer_two_tick) begin
      if (timer_two_count_reg == `WORD_MAX) begin
        timer_two_count_next = {timer_two_reload_high_reg, timer_two_reload_low_reg};
        timer_two_ovf        = 1'b1;
      end else begin
        timer_two_count_next = timer_two_count_reg + 16'h0001;
      end
    end
    if (sfr_wr_i && (sfr_addr_i == `ADDR_LOW2)) begin
      timer_two_count_next[7:0] = sfr_wdata_i;
    end
    if (sfr_wr_i && (sfr_addr_i == `ADDR_HIGH2)) begin
      timer_two_count_next[15:8] = sfr_wdata_i;
    end
  end

  // Timer 2 control: its flag is cleared only by software, set wins.
  always @* begin
    timer_two_control_next = timer_two_control_reg;
    if (wr_ctl2) begin
      timer_two_control_next = sfr_wdata_i;
    end
    if (bit_hit_ctl2) begin
      timer_two_control_next[bit_addr_i[2:0]] = bit_wdata_i;
    end
    if (timer_two_ovf) begin
      timer_two_control_next[`CTL2_FLAG] = 1'b1;
    end
  end

  // The two bytes of a running timer are read apart, so a carry between the reads may tear.
  // Software that needs a clean 16-bit value stops the timer first.
  // Read multiplexer; unmapped addresses read as zero.
  always @* begin
    case (sfr_addr_i)
      `ADDR_CTL01:     rdata_next = timer01_control_reg;
      `ADDR_MODE01:    rdata_next = timer01_mode_reg;
      `ADDR_LOW0:      rdata_next = timer_zero_low_byte;
      `ADDR_LOW1:      rdata_next = timer_one_low_byte;
      `ADDR_HIGH0:     rdata_next = timer_zero_high_byte;
      `ADDR_HIGH1:     rdata_next = timer_one_high_byte;
      `ADDR_CTL2:      rdata_next = timer_two_control_reg;
      `ADDR_RELOAD_LO: rdata_next = timer_two_reload_low_reg;
      `ADDR_RELOAD_HI: rdata_next = timer_two_reload_high_reg;
      `ADDR_LOW2:      rdata_next = timer_two_count_reg[7:0];
      `ADDR_HIGH2:     rdata_next = timer_two_count_reg[15:8];
      default:         rdata_next = `BYTE_RESET;
    endcase
  end

  // Register storage; everything clears on reset so timers start stopped.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      timer01_control_reg       <= `BYTE_RESET;
      timer01_mode_reg          <= `BYTE_RESET;
      timer_two_control_reg     <= `BYTE_RESET;
      timer_two_reload_low_reg  <= `BYTE_RESET;
      timer_two_reload_high_reg <= `BYTE_RESET;
      timer_two_count_reg       <= {`BYTE_RESET, `BYTE_RESET};
      rdata_reg                 <= `BYTE_RESET;
    end else begin
      timer01_control_reg   <= timer01_control_next;
      timer_two_control_reg <= timer_two_control_next;
      timer_two_count_reg   <= timer_two_count_next;
      if (wr_mode01) begin
        timer01_mode_reg <= sfr_wdata_i;
      end
      if (sfr_wr_i && (sfr_addr_i == `ADDR_RELOAD_LO)) begin
        timer_two_reload_low_reg <= sfr_wdata_i;
      end
      if (sfr_wr_i && (sfr_addr_i == `ADDR_RELOAD_HI)) begin
        timer_two_reload_high_reg <= sfr_wdata_i;
      end
      // Read data holds between reads so a slow core may sample it late.
      if (sfr_rd_i) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign sfr_rdata_o                = rdata_reg;
  assign timer_zero_overflow_flag_o = timer01_control_reg[`CTL_FLAG0];
  assign timer_one_overflow_flag_o  = timer01_control_reg[`CTL_FLAG1];
  assign timer_two_overflow_flag_o  = timer_two_control_reg[`CTL2_FLAG];
endmodule // triple_timer_counter_unit
`default_nettype wire

// file: testbench/count_pulse_source.sv
// Far-side pin source: bursts of falling edges on one count pin.
`timescale 1ns/100ps
`default_nettype none
module count_pulse_source (
  input  wire logic       clk_i, // Core clock.
  input  wire logic       go_i,  // Starts a burst.
  input  wire logic [7:0] n_i,   // Falls per burst.
  output var  logic       pin_o  // Count pin, idles high.
);
  logic [8:0] left = 9'h000; // Level changes still due.
  logic       half = 1'b0;   // Second cycle at this level.
  initial pin_o = 1'b1;
  // Each level stands two cycles, so a sampler never misses one.
  always @(posedge clk_i) begin
    if (left == 9'h000) left <= go_i ? {n_i, 1'b0} : 9'h000;
    else begin
      half <= ~half;
      if (half) {pin_o, left} <= {~pin_o, left - 9'h001};
    end
  end
endmodule // count_pulse_source
`default_nettype wire

// file: testbench/timer_unit_checker.sv
// Port assertions for the triple timer/counter unit.
`timescale 1ns/100ps
`default_nettype none
module timer_unit_checker (
  input wire logic       clk_i, sys_rst_i, sfr_wr_i, sfr_rd_i, bit_wr_i, bit_wdata_i,
  input wire logic       vector_timer_zero_i, vector_timer_one_i,
  input wire logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, bit_addr_i,
  input wire logic       timer_zero_overflow_flag_o, timer_one_overflow_flag_o, timer_two_overflow_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic f0 = timer_zero_overflow_flag_o; // Short names for the flags.
  wire logic f1 = timer_one_overflow_flag_o;
  wire logic f2 = timer_two_overflow_flag_o;
  wire logic quiet = !sfr_wr_i && !bit_wr_i; // No write this cycle.
  property p_rst; $fell(sys_rst_i) |-> !f0 && !f1 && !f2; endproperty
  a_rst: assert property (p_rst) else $error("flag set after reset");
  property p_hold; !sfr_rd_i |=> $stable(sfr_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmap; sfr_rd_i && sfr_addr_i < 8'h88 |=> sfr_rdata_o == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_keep0; f0 && quiet && !vector_timer_zero_i |=> f0; endproperty
  a_keep0: assert property (p_keep0) else $error("timer 0 flag lost");
  property p_keep1; f1 && quiet && !vector_timer_one_i |=> f1; endproperty
  a_keep1: assert property (p_keep1) else $error("timer 1 flag lost");
  property p_bitset; bit_wr_i && bit_wdata_i && bit_addr_i == 8'h8F |=> f1; endproperty
  a_bitset: assert property (p_bitset) else $error("bit write missed");
  property p_ctlrd; sfr_rd_i && sfr_addr_i == 8'h88 && quiet |=> sfr_rdata_o[7] == $past(f1)
    && sfr_rdata_o[5] == $past(f0); endproperty
  a_ctlrd: assert property (p_ctlrd) else $error("control read wrong");
  property p_t2wr; sfr_wr_i && !bit_wr_i && sfr_addr_i == 8'hC8 && sfr_wdata_i[7] |=> f2; endproperty
  a_t2wr: assert property (p_t2wr) else $error("timer 2 flag write missed");
endmodule // timer_unit_checker
bind triple_timer_counter_unit timer_unit_checker chk_u (.*);
`default_nettype wire

// file: testbench/triple_timer_counter_unit_tb.sv
// Self-checking bench for the triple timer/counter unit.
`timescale 1ns/100ps
`default_nettype none
module triple_timer_counter_unit_tb;
  logic       clk_i = 1'b0, sys_rst_i = 1'b1, wr = 1'b0, rd = 1'b0, bwr = 1'b0, bdat = 1'b0;
  logic       go = 1'b0, external_interrupt_pin_one = 1'b0, vec0 = 1'b0, vec1 = 1'b0, pin1, f0, f1, f2;
  logic [7:0] addr = 8'h00, wdat = 8'h00, badr = 8'h00, rdat;
  logic [7:0] regs [12] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'h87};
  int         err_total = 0, n_compared = 0, cyc = 0, i;
  always #5 clk_i = ~clk_i;
  count_pulse_source src_u (.clk_i(clk_i), .go_i(go), .n_i(8'h05), .pin_o(pin1));
  triple_timer_counter_unit dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_wdata_i(wdat), .sfr_rdata_o(rdat), .bit_addr_i(badr), .bit_wr_i(bwr), .bit_wdata_i(bdat),
    .count_input_pin_zero_i(1'b1), .count_input_pin_one_i(pin1), .count_input_pin_two_i(pin1),
    .external_interrupt_pin_zero_i(1'b1), .external_interrupt_pin_one_i(external_interrupt_pin_one), .vector_timer_zero_i(vec0),
    .vector_timer_one_i(vec1), .timer_zero_overflow_flag_o(f0), .timer_one_overflow_flag_o(f1),
    .timer_two_overflow_flag_o(f2));
  task automatic chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("FAIL reg %h expected %h seen %h", a, e, g);
    end
  endtask
  task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) {addr, wdat, wr} <= {a, d, 1'b1};
    @(posedge clk_i) wr <= 1'b0;
  endtask
  task automatic bit_w(input logic [7:0] a, input logic v);
    @(posedge clk_i) {badr, bdat, bwr} <= {a, v, 1'b1};
    @(posedge clk_i) bwr <= 1'b0;
  endtask
  task automatic rd_c(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i) {addr, rd} <= {a, 1'b1};
    @(posedge clk_i) rd <= 1'b0;
    #1 chk(a, e, rdat);
  endtask
  task automatic burst;
    @(posedge clk_i) go <= 1'b1;
    @(posedge clk_i) go <= 1'b0;
    repeat (30) @(posedge clk_i);
  endtask
  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // A hang is cut short well past the expected run length.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    foreach (regs[k]) rd_c(regs[k], 8'h00);
    wr_b(8'hCA, 8'h5A);
    wr_b(8'hCB, 8'hA5);
    rd_c(8'hCA, 8'h5A);
    rd_c(8'hCB, 8'hA5);
    // Control registers take bit writes; the mode register must not.
    wr_b(8'hC8, 8'h80);
    #1 chk(8'hC8, 8'h01, {7'h00, f2});
    bit_w(8'hCF, 1'b0);
    bit_w(8'h8B, 1'b1);
    bit_w(8'h90, 1'b1);
    rd_c(8'hC8, 8'h00);
    rd_c(8'h88, 8'h08);
    rd_c(8'h89, 8'h00);
    // Timer 0 reload mode wraps back to the high byte and raises its flag.
    wr_b(8'h89, 8'h02);
    wr_b(8'h8C, 8'hF0);
    wr_b(8'h8A, 8'hFE);
    bit_w(8'h8C, 1'b1);
    for (i = 0; i < 8 && f0 !== 1'b1; i++) @(posedge clk_i);
    chk(8'h88, 8'h01, {7'h00, f0});
    bit_w(8'h8C, 1'b0);
    rd_c(8'h8C, 8'hF0);
    bit_w(8'h8F, 1'b1);
    #1 chk(8'h8F, 8'h01, {7'h00, f1});
    @(posedge clk_i) {vec0, vec1} <= 2'b11;
    @(posedge clk_i) {vec0, vec1} <= 2'b00;
    rd_c(8'h88, 8'h08);
    // Timer 1 counts five pin falls as a 16-bit counter.
    wr_b(8'h89, 8'h50);
    bit_w(8'h8E, 1'b1);
    burst();
    rd_c(8'h8B, 8'h05);
    rd_c(8'h8D, 8'h00);
    // Gated by a low pin, then stopped by mode 11, the count must not move.
    wr_b(8'h89, 8'h90);
    repeat (10) @(posedge clk_i);
    rd_c(8'h8B, 8'h05);
    wr_b(8'h89, 8'hB0);
    @(posedge clk_i) external_interrupt_pin_one <= 1'b1;
    repeat (10) @(posedge clk_i);
    rd_c(8'h8B, 8'h05);
    // Timer 2 counts five falls of its own pin.
    wr_b(8'hC8, 8'h06);
    burst();
    rd_c(8'hCC, 8'h05);
    rd_c(8'hCD, 8'h00);
    // Prescaled mode: two clocks wrap the prescaler and the high byte.
    wr_b(8'h89, 8'h30);
    wr_b(8'h8C, 8'hFF);
    wr_b(8'h8A, 8'hFE);
    bit_w(8'h8C, 1'b1);
    bit_w(8'h8C, 1'b0);
    rd_c(8'h8A, 8'hE0);
    rd_c(8'h8C, 8'h00);
    rd_c(8'h88, 8'h68);
    // Split mode: the high byte counts two clocks under the timer 1 run bit.
    wr_b(8'h89, 8'h33);
    bit_w(8'h8E, 1'b0);
    rd_c(8'h8C, 8'h02);
    complete_run();
  end
endmodule // triple_timer_counter_unit_tb
`default_nettype wire
